// ### rtl/irq_mode_ctrl_map.vh
// Address map, field positions and reset values of the interrupt mode control slots.
// Included by the slot bank and its lane module; definitions only.
`ifndef IRQ_MODE_CTRL_MAP_VH
`define IRQ_MODE_CTRL_MAP_VH

// Register byte addresses
`define IMC_28_31_ADDR 32'hffffe01c
`define IMC_32_35_ADDR 32'hffffe020
`define IRQ_STATUS_ADDR 32'hffffe100
`define IRQ_MASK_ADDR 32'hffffe104

// Reset values
`define IMC_RESET 32'h00000000
`define IRQ_STATUS_RESET 8'h00
`define IRQ_MASK_RESET 8'h00

// Writable bits of a mode register: bits 7 and 3 of each lane stay zero
`define IMC_WR_MASK 32'h77777777

// Field positions inside one 8-bit lane
`define LANE_EDGE_HI 6
`define LANE_EDGE_LO 5
`define LANE_DMA_BIT 4
`define LANE_LEVEL_HI 2
`define LANE_LEVEL_LO 0

// Field encodings
`define EDGE_RISING 2'h3
`define LEVEL_DISABLED 3'h0

// Lane that serves no source (interrupt number 34)
`define RESERVED_LANE 6
`define IRQ_STATUS_WR_MASK 8'hbf

// AHB encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2

`endif

// ### rtl/irq_mode_lane.v
// One interrupt source lane: rising-edge detection and routing to a priority request
// or a DMA channel trigger. Assumes the source is a level from logic on the same clock.
`timescale 1ns/1ps
`include "irq_mode_ctrl_map.vh"

module irq_mode_lane (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Lane configuration byte and source
  input wire [7:0] cfg,
  input wire src,
  // Decoded outcome, valid in the cycle the edge is seen
  output reg hit,
  output reg irq_hit,
  output reg [7:0] dma_hit
);

  reg src_prev_ff;
  wire [1:0] edge_sel;
  wire dma_sel;
  wire [2:0] level_or_channel;
  wire rise;

  assign edge_sel = cfg[`LANE_EDGE_HI:`LANE_EDGE_LO];
  assign dma_sel = cfg[`LANE_DMA_BIT];
  assign level_or_channel = cfg[`LANE_LEVEL_HI:`LANE_LEVEL_LO];

  // Previous level kept even while the lane is off, so enabling it never fakes an edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src;
    end
  end

  // Other edge encodings are not supported and detect nothing
  assign rise = src & ~src_prev_ff & (edge_sel == `EDGE_RISING);

  always @* begin
    hit = 1'b0;
    irq_hit = 1'b0;
    dma_hit = 8'h00;
    if (rise) begin
      if (dma_sel) begin
        hit = 1'b1;
        dma_hit[level_or_channel] = 1'b1;
      end else if (level_or_channel != `LEVEL_DISABLED) begin
        hit = 1'b1;
        irq_hit = 1'b1;
      end
    end
  end

endmodule

// ### rtl/irq_mode_ctrl_slots.v
// Interrupt mode control slots for interrupt numbers 28 to 35, with an AHB-Lite slave,
// sticky event status, mask and one level interrupt.
// Assumes all sources and the bus run on CLK; the master issues single word transfers.
//
// Behaviour
// - Each lane's 2-bit edge field must hold 11 and the lane then reacts to rising edges.
// - The DMA-trigger bit routes a lane's request to a DMA channel when 1, else to an interrupt.
// - As an interrupt, the 3-bit field gives priority 1 to 7, and 000 disables the source.
// - As a DMA trigger, the 3-bit field names DMA channel 0 to 7.
// - The first register's byte lanes serve interrupt numbers 28, 29, 30 and 31 from low to high.
// - The second register's lanes serve numbers 32, 33 and, in the top lane, 35.
// - Each lane holds edge at 6:5, DMA bit at 4, level at 2:0, and bits 7 and 3 read zero.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "irq_mode_ctrl_map.vh"

module irq_mode_ctrl_slots #(
  parameter LANES = 8,
  parameter DMA_CHANNELS = 8
) (
  // Clock and reset
  input wire CLK,
  input wire RESET_N,
  // AHB-Lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // Interrupt sources
  input wire CAPTURE_IRQ,
  input wire COMPARE0_IRQ,
  input wire COMPARE1_IRQ,
  input wire COMPARE2_IRQ,
  input wire COMPARE3_IRQ,
  input wire COMPARE4_IRQ,
  input wire SERIAL3_RX_IRQ,
  // Requests to the processor core, one per lane, with their priority
  output reg [LANES-1:0] IRQ_REQ,
  output reg [3*LANES-1:0] IRQ_LEVEL,
  // Triggers to the DMA controller, one per channel
  output reg [DMA_CHANNELS-1:0] DMA_TRIG,
  // Block interrupt
  output reg INT_OUT
);

  // Mode registers
  reg [31:0] irq_mode_ctrl_28_31_ff;
  reg [31:0] irq_mode_ctrl_32_35_ff;
  reg [31:0] nxt_irq_mode_ctrl_28_31;
  reg [31:0] nxt_irq_mode_ctrl_32_35;

  // Event status and mask
  reg [LANES-1:0] status_ff;
  reg [LANES-1:0] mask_ff;
  reg [LANES-1:0] nxt_status;
  reg [LANES-1:0] nxt_mask;

  // Data phase bookkeeping
  reg wr_pend_ff;
  reg [31:0] wr_addr_ff;
  reg [31:0] nxt_rdata;

  // Lane wiring
  wire [63:0] cfg_all;
  wire [LANES-1:0] src_vec;
  wire [LANES-1:0] lane_hit;
  wire [LANES-1:0] lane_irq_hit;
  wire [8*LANES-1:0] lane_dma_hit;
  reg [DMA_CHANNELS-1:0] dma_any;
  reg [3*LANES-1:0] nxt_level;

  // Address and data phase qualifiers
  wire addr_valid;
  wire addr_write;
  wire addr_read;
  wire wr_28_31;
  wire wr_32_35;
  wire wr_status;
  wire wr_mask;
  wire [7:0] wdata_status;

  integer c;
  integer l;
  integer m;

  // Lane order: low byte of the first register is number 28, top byte of the second is 35
  assign cfg_all = {irq_mode_ctrl_32_35_ff, irq_mode_ctrl_28_31_ff};

  // Lane 6 is number 34 and has no source
  assign src_vec = {SERIAL3_RX_IRQ,
                    1'b0,
                    COMPARE4_IRQ,
                    COMPARE3_IRQ,
                    COMPARE2_IRQ,
                    COMPARE1_IRQ,
                    COMPARE0_IRQ,
                    CAPTURE_IRQ};

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      irq_mode_lane u_lane (
        .clk(CLK),
        .reset_n(RESET_N),
        .cfg(cfg_all[8*g+7:8*g]),
        .src(src_vec[g]),
        .hit(lane_hit[g]),
        .irq_hit(lane_irq_hit[g]),
        .dma_hit(lane_dma_hit[8*g+7:8*g])
      );
    end
  endgenerate

  // Bus address phase
  assign addr_valid = HSEL & HTRANS[`HTRANS_NONSEQ_BIT] & HREADY;
  assign addr_write = addr_valid & HWRITE;
  assign addr_read = addr_valid & ~HWRITE;

  // Write data is taken in the data phase, one cycle after the address
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h00000000;
    end else begin
      wr_pend_ff <= addr_write;
      if (addr_write) begin
        wr_addr_ff <= HADDR;
      end
    end
  end

  assign wr_28_31 = wr_pend_ff & (wr_addr_ff == `IMC_28_31_ADDR);
  assign wr_32_35 = wr_pend_ff & (wr_addr_ff == `IMC_32_35_ADDR);
  assign wr_status = wr_pend_ff & (wr_addr_ff == `IRQ_STATUS_ADDR);
  assign wr_mask = wr_pend_ff & (wr_addr_ff == `IRQ_MASK_ADDR);
  assign wdata_status = HWDATA[7:0];

  // Mode registers: reserved bits 7 and 3 of each lane are never stored
  always @* begin
    nxt_irq_mode_ctrl_28_31 = irq_mode_ctrl_28_31_ff;
    nxt_irq_mode_ctrl_32_35 = irq_mode_ctrl_32_35_ff;
    if (wr_28_31) begin
      nxt_irq_mode_ctrl_28_31 = HWDATA & `IMC_WR_MASK;
    end
    // The unused lane stores what is written; software is expected to keep it zero
    if (wr_32_35) begin
      nxt_irq_mode_ctrl_32_35 = HWDATA & `IMC_WR_MASK;
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_mode_ctrl_28_31_ff <= `IMC_RESET;
      irq_mode_ctrl_32_35_ff <= `IMC_RESET;
    end else begin
      irq_mode_ctrl_28_31_ff <= nxt_irq_mode_ctrl_28_31;
      irq_mode_ctrl_32_35_ff <= nxt_irq_mode_ctrl_32_35;
    end
  end

  // Status: write one to clear, and a new event in the same cycle wins over the clear
  always @* begin
    nxt_status = status_ff;
    if (wr_status) begin
      nxt_status = status_ff & ~wdata_status;
    end
    nxt_status = (nxt_status | lane_hit) & `IRQ_STATUS_WR_MASK;
  end

  always @* begin
    nxt_mask = mask_ff;
    if (wr_mask) begin
      nxt_mask = wdata_status & `IRQ_STATUS_WR_MASK;
    end
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_ff <= `IRQ_STATUS_RESET;
      mask_ff <= `IRQ_MASK_RESET;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
    end
  end

  // Read data uses the next register values so a read right after a write sees it
  always @* begin
    nxt_rdata = 32'h00000000;
    case (HADDR)
      `IMC_28_31_ADDR: begin
        nxt_rdata = nxt_irq_mode_ctrl_28_31;
      end
      `IMC_32_35_ADDR: begin
        nxt_rdata = nxt_irq_mode_ctrl_32_35;
      end
      `IRQ_STATUS_ADDR: begin
        nxt_rdata = {24'h000000, nxt_status};
      end
      `IRQ_MASK_ADDR: begin
        nxt_rdata = {24'h000000, nxt_mask};
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // Zero wait states; unmapped addresses read zero and ignore writes, always OKAY
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (addr_read) begin
        HRDATA <= nxt_rdata;
      end else begin
        HRDATA <= 32'h00000000;
      end
    end
  end

  // Several lanes may trigger the same channel in one cycle; they merge into one pulse
  always @* begin
    dma_any = {DMA_CHANNELS{1'b0}};
    for (l = 0; l < LANES; l = l + 1) begin
      for (c = 0; c < DMA_CHANNELS; c = c + 1) begin
        dma_any[c] = dma_any[c] | lane_dma_hit[8*l+c];
      end
    end
  end

  // Level shown with a request is the one programmed when the edge was seen
  always @* begin
    nxt_level = IRQ_LEVEL;
    for (m = 0; m < LANES; m = m + 1) begin
      if (lane_irq_hit[m]) begin
        nxt_level[3*m+2] = cfg_all[8*m+`LANE_LEVEL_HI];
        nxt_level[3*m+1] = cfg_all[8*m+1];
        nxt_level[3*m] = cfg_all[8*m+`LANE_LEVEL_LO];
      end
    end
  end

  // Request and trigger pulses last one cycle
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_REQ <= {LANES{1'b0}};
      IRQ_LEVEL <= {3*LANES{1'b0}};
      DMA_TRIG <= {DMA_CHANNELS{1'b0}};
    end else begin
      IRQ_REQ <= lane_irq_hit;
      IRQ_LEVEL <= nxt_level;
      DMA_TRIG <= dma_any;
    end
  end

  // Interrupt follows the registered status, one cycle behind it
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INT_OUT <= 1'b0;
    end else begin
      INT_OUT <= |(status_ff & mask_ff);
    end
  end

endmodule

// ### testbench/irq_slots_monitor.sv
// Checker on the slot bank's ports: bus answers, request causes, pulse shapes.
// Assumes sources and bus share CLK.
`timescale 1ns/1ps
`include "irq_mode_ctrl_map.vh"
module irq_slots_monitor (
  // Clock and reset
  input wire CLK,
  input wire RESET_N,
  // Bus
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  // Sources
  input wire CAPTURE_IRQ,
  input wire COMPARE0_IRQ,
  input wire COMPARE1_IRQ,
  input wire COMPARE2_IRQ,
  input wire COMPARE3_IRQ,
  input wire COMPARE4_IRQ,
  input wire SERIAL3_RX_IRQ,
  // Outcomes
  input wire [7:0] IRQ_REQ,
  input wire [23:0] IRQ_LEVEL,
  input wire [7:0] DMA_TRIG
);
  // Lane 6 has no source, so its bit stays low
  wire [7:0] srcs = {SERIAL3_RX_IRQ, 1'b0, COMPARE4_IRQ, COMPARE3_IRQ, COMPARE2_IRQ,
    COMPARE1_IRQ, COMPARE0_IRQ, CAPTURE_IRQ};
  reg [7:0] prev_ff;
  reg [7:0] rise_ff;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prev_ff <= 8'h00;
      rise_ff <= 8'h00;
    end else begin
      prev_ff <= srcs;
      rise_ff <= srcs & ~prev_ff;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_rd;
    HSEL && HTRANS[1] && !HWRITE && HREADY;
  endsequence
  sequence s_rd_mode;
    s_rd ##0 (HADDR == `IMC_28_31_ADDR || HADDR == `IMC_32_35_ADDR);
  endsequence
  sequence s_rd_void;
    s_rd ##0 !(HADDR inside {`IMC_28_31_ADDR, `IMC_32_35_ADDR, `IRQ_STATUS_ADDR, `IRQ_MASK_ADDR});
  endsequence
  a_ready_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  a_mode_rsvd: assert property (s_rd_mode |=> (HRDATA & ~`IMC_WR_MASK) == 32'h0)
    else $error("mode register read shows fixed-zero bits");
  a_void_zero: assert property (s_rd_void |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (HRDATA != 32'h0 |-> $past(HSEL && HTRANS[1] && !HWRITE && HREADY))
    else $error("read data outside a read data phase");
  a_req_cause: assert property ((IRQ_REQ & ~rise_ff) == 8'h00)
    else $error("request without rising edge of its source");
  a_dma_cause: assert property (DMA_TRIG != 8'h00 |-> rise_ff != 8'h00)
    else $error("dma trigger without a source edge");
  a_req_pulse: assert property ((IRQ_REQ & $past(IRQ_REQ)) == 8'h00)
    else $error("request longer than one cycle");
  a_level_hold: assert property (!$stable(IRQ_LEVEL) |-> IRQ_REQ != 8'h00)
    else $error("level changed without a request");
endmodule

// ### testbench/core_dma_sink.sv
// Stand-in for the core's request input and the DMA controller's trigger input.
// Counts every request or trigger cycle and keeps the last one seen.
`timescale 1ns/1ps
module core_dma_sink (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Pulses from the slot bank
  input wire [7:0] irq_req,
  input wire [23:0] irq_level,
  input wire [7:0] dma_trig,
  // What was seen
  output reg [7:0] ev_cnt_ff,
  output reg [7:0] last_irq_ff,
  output reg [7:0] last_dma_ff
);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_cnt_ff <= 8'h00;
      last_irq_ff <= 8'h00;
      last_dma_ff <= 8'h00;
    end else if (irq_req != 8'h00 || dma_trig != 8'h00) begin
      // Pulses last one cycle, so each is taken on the edge it stands
      ev_cnt_ff <= ev_cnt_ff + 8'h01;
      last_irq_ff <= irq_req;
      last_dma_ff <= dma_trig;
    end
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench of the slot bank: AHB-Lite master tasks, source pulses, sink model.
// Assumes one 25 MHz clock for bus and sources; HREADY is fed back from HREADYOUT.
`timescale 1ns/1ps
`include "irq_mode_ctrl_map.vh"
module tb_top;
  reg CLK = 1'b0;
  reg RESET_N = 1'b0;
  reg HSEL = 1'b0;
  reg [31:0] HADDR = 32'h0;
  reg [1:0] HTRANS = 2'h0;
  reg HWRITE = 1'b0;
  reg [31:0] HWDATA = 32'h0;
  reg [7:0] src = 8'h00;
  wire [31:0] HRDATA;
  wire HREADYOUT;
  wire HRESP;
  wire [7:0] IRQ_REQ;
  wire [23:0] IRQ_LEVEL;
  wire [7:0] DMA_TRIG;
  wire INT_OUT;
  wire [7:0] ev_cnt;
  wire [7:0] last_irq;
  wire [7:0] last_dma;
  integer miscompares = 0;
  integer comparisons = 0;
  integer i;
  reg [7:0] n;
  reg [31:0] rd;
  always #20 CLK = ~CLK;
  irq_mode_ctrl_slots dut (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(`HSIZE_WORD), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CAPTURE_IRQ(src[0]),
    .COMPARE0_IRQ(src[1]), .COMPARE1_IRQ(src[2]), .COMPARE2_IRQ(src[3]), .COMPARE3_IRQ(src[4]),
    .COMPARE4_IRQ(src[5]), .SERIAL3_RX_IRQ(src[7]), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
    .DMA_TRIG(DMA_TRIG), .INT_OUT(INT_OUT));
  core_dma_sink sink (.clk(CLK), .reset_n(RESET_N), .irq_req(IRQ_REQ), .irq_level(IRQ_LEVEL),
    .dma_trig(DMA_TRIG), .ev_cnt_ff(ev_cnt), .last_irq_ff(last_irq), .last_dma_ff(last_dma));
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // One single transfer; waits on ready in both phases
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      HSEL <= 1'b1;
      HADDR <= a;
      HTRANS <= 2'h2;
      HWRITE <= w;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      rd = HRDATA;
    end
  endtask
  task rc(input [31:0] a, input [31:0] exp, input string what);
    begin
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
    end
  endtask
  task pulse(input [7:0] s);
    begin
      n = ev_cnt;
      @(posedge CLK);
      src <= s;
      @(posedge CLK);
      src <= 8'h00;
      repeat (3) @(posedge CLK);
    end
  endtask
  task t_reset;
    begin
      rc(`IMC_28_31_ADDR, 32'h0, "mode28");
      rc(`IMC_32_35_ADDR, 32'h0, "mode32");
      rc(`IRQ_STATUS_ADDR, 32'h0, "status");
      rc(`IRQ_MASK_ADDR, 32'h0, "mask");
      pulse(8'hff);
      chk("reset edges", 32'h0, ev_cnt);
    end
  endtask
  task t_fields;
    begin
      bus(1'b1, `IMC_28_31_ADDR, 32'hffffffff);
      rc(`IMC_28_31_ADDR, 32'h77777777, "fixed28");
      // Unused lane kept at zero, as software must
      bus(1'b1, `IMC_32_35_ADDR, 32'hff00ffff);
      rc(`IMC_32_35_ADDR, 32'h77007777, "fixed32");
      bus(1'b1, 32'hffffe030, 32'hffffffff);
      rc(32'hffffe030, 32'h0, "unmapped");
      bus(1'b1, `IRQ_MASK_ADDR, 32'hffffffff);
      rc(`IRQ_MASK_ADDR, 32'hbf, "mask bits");
    end
  endtask
  task t_codes;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        bus(1'b1, `IMC_28_31_ADDR, 32'h60 | (i & 7) | ((i & 8) << 1));
        pulse(8'h01);
        chk("events", n + (i != 0), ev_cnt);
        if (i > 0 && i < 8) chk("level", i, IRQ_LEVEL[2:0]);
        if (i > 7) chk("channel", 32'h1 << (i - 8), last_dma);
      end
    end
  endtask
  task t_map;
    begin
      bus(1'b1, `IMC_28_31_ADDR, 32'h45607261);
      bus(1'b1, `IMC_32_35_ADDR, 32'h67007764);
      bus(1'b1, `IRQ_STATUS_ADDR, 32'hff);
      pulse(8'hff);
      chk("one cycle", n + 1, ev_cnt);
      chk("irq lanes", 32'h91, last_irq);
      chk("dma chans", 32'h84, last_dma);
      chk("levels", 32'he04001, IRQ_LEVEL);
      rc(`IRQ_STATUS_ADDR, 32'hb3, "status");
      chk("int on", 32'h1, INT_OUT);
      bus(1'b1, `IRQ_MASK_ADDR, 32'h40);
      repeat (2) @(posedge CLK);
      chk("int masked", 32'h0, INT_OUT);
      bus(1'b1, `IRQ_MASK_ADDR, 32'hff);
      bus(1'b1, `IRQ_STATUS_ADDR, 32'hff);
      repeat (2) @(posedge CLK);
      chk("int clear", 32'h0, INT_OUT);
      rc(`IRQ_STATUS_ADDR, 32'h0, "w1c");
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset;
    t_fields;
    t_codes;
    t_map;
    test_done;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (5000) @(posedge CLK);
    miscompares = miscompares + 1;
    test_done;
  end
endmodule
bind irq_mode_ctrl_slots irq_slots_monitor mon (.CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .CAPTURE_IRQ, .COMPARE0_IRQ, .COMPARE1_IRQ,
  .COMPARE2_IRQ, .COMPARE3_IRQ, .COMPARE4_IRQ, .SERIAL3_RX_IRQ, .IRQ_REQ, .IRQ_LEVEL, .DMA_TRIG);
